// >>> failover_pkg.sv
package failover_pkg;
	localparam int CLOCK_HZ = 40_000_000;
	localparam int ATTACK_MS = 500;
	localparam int RELEASE_MS = 1500;
	localparam int ATTACK_CYCLES = ATTACK_MS * (CLOCK_HZ / 1000);
	localparam int RELEASE_CYCLES = RELEASE_MS * (CLOCK_HZ / 1000);
	localparam int TIMER_W = 26;
	localparam int BAUD = 9600;
	localparam int BIT_CYCLES = CLOCK_HZ / BAUD;
	localparam int BIT_W = 13;
	localparam int DATA_BITS = 8;
	localparam int PAGES = 8;
	localparam int CHARS_PER_LINE = 30;
	localparam int TEXT_LINES = 2;
	localparam int CHARS_PER_PAGE = CHARS_PER_LINE * TEXT_LINES;
	localparam int MEM_WORDS = PAGES * CHARS_PER_PAGE;
	localparam int CELL_PIXELS = 24;
	localparam int ACTIVE_LINES = 576;
	localparam logic [9:0] BANNER_TOP = 10'h180;
	localparam logic [9:0] TEXT_TOP = 10'h1C8;
	localparam logic [9:0] TEXT_BOTTOM = 10'h1F8;
	localparam logic [9:0] TEXT_RIGHT = 10'h2D0;
	localparam logic [3:0] CODE_BARS = 4'h8;
	localparam logic [3:0] CODE_PAGE_LIMIT = 4'h8;
	localparam logic [5:0] LAST_POS = 6'h3B;
	localparam logic [7:0] BLANK_CHAR = 8'h20;

	typedef enum logic [1:0] {
		VIDEO_OK = 2'b00,
		ATTACK = 2'b01,
		FAILED = 2'b11,
		RELEASE = 2'b10
	} fail_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} rx_state_t;

	typedef enum logic [1:0] {
		PAT_MESSAGE = 2'b00,
		PAT_BARS = 2'b01,
		PAT_BLACK = 2'b10
	} pattern_t;

	typedef struct packed {
		logic bypass;
		logic overlay_enable;
		logic bars_only;
	} panel_t;

	typedef struct packed {
		logic override_n;
		logic overlay_kill_n;
		logic bars_only_n;
		logic lamp_test_n;
	} remote_t;

	typedef struct packed {
		logic bars;
		logic banner;
		logic text_cell;
		logic [7:0] char_code;
		logic [4:0] glyph_x;
		logic [4:0] glyph_y;
	} raster_t;
endpackage

// >>> serial_receiver.sv
`timescale 1ns/1ps
module serial_receiver
	import failover_pkg::*;
#(
	parameter int BIT_TIME = BIT_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic rx,
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	rx_state_t state;
	logic [BIT_W-1:0] timer;
	logic [2:0] bit_index;
	logic [7:0] shift;
	logic bit_done;
	logic half_done;

	assign bit_done = timer == BIT_W'(BIT_TIME - 1);
	assign half_done = timer == BIT_W'(BIT_TIME / 2 - 1);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= RX_IDLE;
			timer <= '0;
			bit_index <= 3'h0;
			shift <= 8'h00;
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			timer <= timer + 1'b1;
			case (state)
				RX_IDLE: begin
					timer <= '0;
					if (!rx) begin
						state <= RX_START;
					end
				end
				RX_START: begin
					if (half_done) begin
						timer <= '0;
						bit_index <= 3'h0;
						state <= rx ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (bit_done) begin
						timer <= '0;
						shift <= {rx, shift[7:1]};
						bit_index <= bit_index + 1'b1;
						if (bit_index == 3'(DATA_BITS - 1)) begin
							state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (bit_done) begin
						state <= RX_IDLE;
						rx_byte <= shift;
						rx_valid <= rx;
					end
				end
				default: state <= RX_IDLE;
			endcase
		end
	end

	a_byte_needs_stop: assert property (@(posedge clock) disable iff (!nrst)
		rx_valid |-> $past(state) == RX_STOP && $past(rx))
		else $error("byte accepted without a valid stop bit");
endmodule

// >>> video_failover_controller.sv
`timescale 1ns/1ps
// Overview of operation
// - Test signal inserted only after 0.5 s of continuous invalid video.
// - Returned valid video is switched back within 1.5 s.
// - Grounded remote override forces generator onto switched output.
// - Front-panel bypass forces generator onto switched output likewise.
// - Video-loss indicator lights when video is absent and test signal inserted.
// - Generator output carries the test pattern continuously.
// - Front-panel switch enables or disables the overlay generator.
// - Grounded overlay-kill input removes the overlay.
// - Overlay is two lines of 30 cells, 24x24 pixels, bottom third, on banner.
// - Message mode: bars in top two-thirds, text lines in bottom third.
// - Eight selectable messages are stored.
// - Pattern comes from rotary switch or external 4-bit code.
// - Select lines idle high; a low-pulling party selects.
// - Switch or remote chooses message display or full-screen bars.
// - Programming link is 9600 baud, 8 data bits, no parity, one stop.
// - Grounded indicator-test input lights all indicators.
// - Rotary chooses one of eight pages, full bars or full black.
module video_failover_controller
	import failover_pkg::*;
#(
	parameter int ATTACK_TIME = ATTACK_CYCLES,
	parameter int RELEASE_TIME = RELEASE_CYCLES,
	parameter int BIT_TIME = BIT_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic video_valid,
	input wire panel_t panel,
	input wire remote_t remote,
	input wire logic [3:0] rotary_code,
	input wire logic [3:0] select_in,
	output logic [3:0] select_out,
	output logic [3:0] select_oe_n,
	input wire logic serial_rx,
	input wire logic [9:0] pixel_x,
	input wire logic [9:0] line_y,
	output logic relay_to_generator,
	output logic video_loss_indicator,
	output logic overlay_indicator,
	output pattern_t pattern,
	output raster_t raster
);
	fail_state_t state;
	fail_state_t next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic detector_fail;
	logic forced;
	logic next_relay;
	logic lamp_test;
	logic [3:0] code;
	logic is_page;
	logic [2:0] page;
	logic [2:0] write_page;
	logic [5:0] write_pos;
	logic overlay_on;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic [4:0] column;
	logic text_row;
	logic in_text;
	logic in_banner;
	logic [7:0] msg_mem [0:MEM_WORDS-1];

	function automatic logic [8:0] msg_addr(input logic [2:0] pg, input logic [5:0] pos);
		msg_addr = 9'(pg) * 9'(CHARS_PER_PAGE) + 9'(pos);
	endfunction

	assign forced = !remote.override_n || panel.bypass;
	assign detector_fail = state == FAILED || state == RELEASE;
	assign next_relay = forced || detector_fail;
	assign lamp_test = !remote.lamp_test_n;

	always_comb begin
		next_state = state;
		next_timer = timer + 1'b1;
		case (state)
			VIDEO_OK: begin
				next_timer = '0;
				if (!video_valid) begin
					next_state = ATTACK;
				end
			end
			ATTACK: begin
				if (video_valid) begin
					next_state = VIDEO_OK;
					next_timer = '0;
				end else if (timer == TIMER_W'(ATTACK_TIME - 1)) begin
					next_state = FAILED;
					next_timer = '0;
				end
			end
			FAILED: begin
				next_timer = '0;
				if (video_valid) begin
					next_state = RELEASE;
				end
			end
			RELEASE: begin
				if (!video_valid) begin
					next_state = FAILED;
					next_timer = '0;
				end else if (timer == TIMER_W'(RELEASE_TIME - 1)) begin
					next_state = VIDEO_OK;
					next_timer = '0;
				end
			end
			default: begin
				next_state = VIDEO_OK;
				next_timer = '0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= VIDEO_OK;
			timer <= '0;
			relay_to_generator <= 1'b0;
			video_loss_indicator <= 1'b0;
			overlay_indicator <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			relay_to_generator <= next_relay;
			video_loss_indicator <= lamp_test || (next_relay && detector_fail);
			overlay_indicator <= lamp_test || overlay_on;
		end
	end

	// Tally: pull a line low where the rotary bit is zero; the line level is the code.
	assign select_out = 4'h0;
	assign select_oe_n = rotary_code;
	assign code = select_in;
	assign is_page = code < CODE_PAGE_LIMIT;
	assign page = code[2:0];

	always_comb begin
		if (panel.bars_only || !remote.bars_only_n) begin
			pattern = PAT_BARS;
		end else if (is_page) begin
			pattern = PAT_MESSAGE;
		end else if (code == CODE_BARS) begin
			pattern = PAT_BARS;
		end else begin
			pattern = PAT_BLACK;
		end
	end

	assign overlay_on = pattern == PAT_MESSAGE && panel.overlay_enable && remote.overlay_kill_n;

	serial_receiver #(
		.BIT_TIME(BIT_TIME)
	) receiver (
		.clock(clock),
		.nrst(nrst),
		.rx(serial_rx),
		.rx_byte(rx_byte),
		.rx_valid(rx_valid)
	);

	// Incoming characters fill the selected page in order; a new page restarts at cell zero.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			write_page <= 3'h0;
			write_pos <= 6'h00;
		end else begin
			write_page <= page;
			if (page != write_page) begin
				write_pos <= 6'h00;
			end else if (rx_valid && is_page) begin
				write_pos <= (write_pos == LAST_POS) ? 6'h00 : write_pos + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rx_valid && is_page && page == write_page) begin
			msg_mem[msg_addr(page, write_pos)] <= rx_byte;
		end
	end

	assign in_banner = line_y >= BANNER_TOP && line_y < 10'(ACTIVE_LINES);
	assign in_text = line_y >= TEXT_TOP && line_y < TEXT_BOTTOM && pixel_x < TEXT_RIGHT;
	assign column = 5'(pixel_x / 10'(CELL_PIXELS));
	assign text_row = line_y >= TEXT_TOP + 10'(CELL_PIXELS);

	// The generator raster runs regardless of the relay.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			raster <= '0;
		end else begin
			raster.bars <= pattern == PAT_BARS || (pattern == PAT_MESSAGE && !(overlay_on && in_banner));
			raster.banner <= overlay_on && in_banner;
			raster.text_cell <= overlay_on && in_text;
			raster.char_code <= (overlay_on && in_text) ?
				msg_mem[msg_addr(page, 6'(text_row) * 6'(CHARS_PER_LINE) + 6'(column))] : BLANK_CHAR;
			raster.glyph_x <= 5'(pixel_x % 10'(CELL_PIXELS));
			raster.glyph_y <= 5'((line_y - TEXT_TOP) % 10'(CELL_PIXELS));
		end
	end

	logic [TIMER_W:0] low_run;
	logic [TIMER_W:0] high_run;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			low_run <= '0;
			high_run <= '0;
		end else begin
			low_run <= video_valid ? '0 : low_run + 1'b1;
			high_run <= video_valid ? high_run + 1'b1 : '0;
		end
	end

	a_attack_delay: assert property (@(posedge clock) disable iff (!nrst)
		state == ATTACK && next_state == FAILED |-> low_run >= (TIMER_W+1)'(ATTACK_TIME))
		else $error("inserted before the attack delay");
	a_release_bound: assert property (@(posedge clock) disable iff (!nrst)
		high_run > (TIMER_W+1)'(RELEASE_TIME) |-> !detector_fail)
		else $error("input video not restored within release time");
	a_valid_routes: assert property (@(posedge clock) disable iff (!nrst)
		state == VIDEO_OK && !forced |=> !relay_to_generator)
		else $error("valid video not routed");
	a_override_forces: assert property (@(posedge clock) disable iff (!nrst)
		!remote.override_n |=> relay_to_generator)
		else $error("override ignored");
	a_bypass_forces: assert property (@(posedge clock) disable iff (!nrst)
		panel.bypass |=> relay_to_generator)
		else $error("bypass ignored");
	a_loss_indicator: assert property (@(posedge clock) disable iff (!nrst)
		video_loss_indicator && !$past(lamp_test) |-> relay_to_generator && $past(detector_fail))
		else $error("video-loss indicator without inserted signal");
	a_lamp_test: assert property (@(posedge clock) disable iff (!nrst)
		lamp_test |=> video_loss_indicator && overlay_indicator)
		else $error("indicator test did not light all indicators");
	a_overlay_kill: assert property (@(posedge clock) disable iff (!nrst)
		!remote.overlay_kill_n || !panel.overlay_enable |=> !raster.banner && !raster.text_cell)
		else $error("overlay shown while disabled");
	a_timer_restart: assert property (@(posedge clock) disable iff (!nrst)
		state == ATTACK && video_valid |=> state == VIDEO_OK && timer == '0)
		else $error("attack timer did not restart");
endmodule

// >>> far_side.sv
`timescale 1ns/1ps
module far_side
	import failover_pkg::*;
#(
	parameter int BIT_TIME = 16
) (
	input wire logic clock,
	input wire logic [3:0] select_oe_n,
	input wire logic [3:0] select_out,
	output logic [3:0] select_in,
	output logic video_valid,
	output logic serial_rx,
	output panel_t panel,
	output remote_t remote
);
	logic [3:0] pull_low;
	// A line reads high unless some party pulls it low.
	assign select_in = ~((~select_oe_n & ~select_out) | pull_low);
	initial begin
		pull_low = 4'h0;
		video_valid = 1'b1;
		serial_rx = 1'b1;
		panel = 3'b010;
		remote = 4'hF;
	end
	task automatic set_video(input logic v);
		video_valid = v;
	endtask
	task automatic set_panel(input panel_t p);
		panel = p;
	endtask
	task automatic set_remote(input remote_t r);
		remote = r;
	endtask
	task automatic pick(input logic [3:0] code);
		@(negedge clock);
		pull_low = ~code;
	endtask
	// One start bit, eight data bits from the least significant, one stop bit.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clock);
			serial_rx = frame[i];
			repeat (BIT_TIME - 1) @(negedge clock);
		end
		repeat (BIT_TIME) @(negedge clock);
	endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
	import failover_pkg::*;
	localparam int AT = 20;
	localparam int RT = 40;
	localparam int BT = 16;
	localparam logic [20:0] ALL = 21'h1FFFFF;
	localparam logic [20:0] TOP = 21'h1C0000;
	logic clock = 1'b0;
	logic nrst;
	logic [9:0] pixel_x;
	logic [9:0] line_y;
	logic [3:0] rotary_code;
	logic [3:0] select_in, select_out, select_oe_n;
	logic video_valid, serial_rx, relay_to_generator, video_loss_indicator;
	logic overlay_indicator;
	panel_t panel;
	remote_t remote;
	pattern_t pattern;
	raster_t raster;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #12.5 clock = ~clock;
	video_failover_controller #(.ATTACK_TIME(AT), .RELEASE_TIME(RT), .BIT_TIME(BT)) i_dut (
		.clock(clock), .nrst(nrst), .video_valid(video_valid), .panel(panel),
		.remote(remote), .rotary_code(rotary_code), .select_in(select_in),
		.select_out(select_out), .select_oe_n(select_oe_n), .serial_rx(serial_rx),
		.pixel_x(pixel_x), .line_y(line_y), .relay_to_generator(relay_to_generator),
		.video_loss_indicator(video_loss_indicator), .overlay_indicator(overlay_indicator),
		.pattern(pattern), .raster(raster));
	far_side #(.BIT_TIME(BT)) i_far (
		.clock(clock), .select_oe_n(select_oe_n), .select_out(select_out),
		.select_in(select_in), .video_valid(video_valid), .serial_rx(serial_rx),
		.panel(panel), .remote(remote));
	task automatic stop_test;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Counts cycles until the relay reaches e; the count must lie in [lo, hi].
	task automatic timed(input logic e, input int lo, input int hi);
		int n;
		n = 0;
		while (relay_to_generator !== e && n <= hi) begin
			@(negedge clock);
			n++;
		end
		check("relay_delay", (n >= lo && n <= hi), 1'b1);
	endtask
	task automatic px(input string what, input int x, input int y, input logic [20:0] m,
		input logic [20:0] e);
		pixel_x = x[9:0];
		line_y = y[9:0];
		@(negedge clock);
		check(what, raster & m, e);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			stop_test;
		end
	end
	initial begin
		nrst = 1'b0;
		pixel_x = 10'h000;
		line_y = 10'h000;
		rotary_code = 4'hF;
		repeat (12) @(negedge clock);
		check("relay_reset", relay_to_generator, 1'b0);
		nrst = 1'b1;
		repeat (3) @(negedge clock);
		check("relay_valid", relay_to_generator, 1'b0);
		i_far.set_video(1'b0);
		repeat (AT - 5) @(negedge clock);
		i_far.set_video(1'b1);
		repeat (3) @(negedge clock);
		i_far.set_video(1'b0);
		repeat (AT - 5) @(negedge clock);
		check("relay_glitch", relay_to_generator, 1'b0);
		i_far.set_video(1'b1);
		repeat (5) @(negedge clock);
		i_far.set_video(1'b0);
		timed(1'b1, AT, AT + 5);
		repeat (2) @(negedge clock);
		check("loss_lit", video_loss_indicator, 1'b1);
		check("gen_pattern", pattern, PAT_BLACK);
		i_far.set_video(1'b1);
		timed(1'b0, RT, RT + 5);
		repeat (2) @(negedge clock);
		check("loss_dark", video_loss_indicator, 1'b0);
		i_far.set_remote(4'h7);
		timed(1'b1, 0, 3);
		repeat (2) @(negedge clock);
		check("loss_override", video_loss_indicator, 1'b0);
		i_far.set_remote(4'hF);
		timed(1'b0, 0, RT + 5);
		i_far.set_panel(3'h6);
		timed(1'b1, 0, 3);
		i_far.set_panel(3'h2);
		timed(1'b0, 0, RT + 5);
		check("overlay_lamp_idle", overlay_indicator, 1'b0);
		i_far.set_remote(4'hE);
		repeat (2) @(negedge clock);
		check("lamp_test", video_loss_indicator, 1'b1);
		check("lamp_test_overlay", overlay_indicator, 1'b1);
		i_far.set_remote(4'hF);
		for (int c = 0; c < 16; c++) begin
			i_far.pick(c[3:0]);
			@(negedge clock);
			check("pattern_code", pattern, c < 8 ? PAT_MESSAGE : c == 8 ? PAT_BARS : PAT_BLACK);
		end
		rotary_code = 4'h7;
		@(negedge clock);
		check("tally", select_in, 4'h7);
		check("rotary_page", pattern, PAT_MESSAGE);
		rotary_code = 4'hF;
		i_far.pick(4'h0);
		i_far.set_panel(3'h3);
		@(negedge clock);
		check("bars_panel", pattern, PAT_BARS);
		i_far.set_panel(3'h2);
		i_far.set_remote(4'hD);
		@(negedge clock);
		check("bars_remote", pattern, PAT_BARS);
		i_far.set_remote(4'hF);
		repeat (3) @(negedge clock);
		i_far.send_byte(8'h41);
		i_far.send_byte(8'h5A);
		i_far.pick(4'h7);
		repeat (3) @(negedge clock);
		i_far.send_byte(8'h37);
		i_far.pick(4'h0);
		repeat (3) @(negedge clock);
		px("char_second", 24, 461, ALL, {3'b011, 8'h5A, 5'h00, 5'h05});
		px("char_first", 23, 456, ALL, {3'b011, 8'h41, 5'h17, 5'h00});
		px("right_edge", 720, 460, TOP, 21'h080000);
		px("top_bars", 100, 100, TOP, 21'h100000);
		px("above_banner", 0, 383, TOP, 21'h100000);
		px("banner_start", 0, 384, TOP, 21'h080000);
		i_far.pick(4'h7);
		px("page_last", 0, 456, ALL, {3'b011, 8'h37, 5'h00, 5'h00});
		i_far.pick(4'h0);
		i_far.set_remote(4'hB);
		px("overlay_kill", 0, 460, TOP, 21'h100000);
		check("overlay_lamp_kill", overlay_indicator, 1'b0);
		i_far.set_remote(4'hF);
		i_far.set_panel(3'h0);
		px("overlay_off", 0, 460, TOP, 21'h100000);
		check("overlay_lamp_off", overlay_indicator, 1'b0);
		i_far.set_panel(3'h2);
		px("overlay_back", 0, 460, TOP, 21'h0C0000);
		check("overlay_lamp_on", overlay_indicator, 1'b1);
		i_far.pick(4'h8);
		px("bars_full", 0, 460, TOP, 21'h100000);
		i_far.pick(4'h9);
		px("black_full", 0, 460, TOP, 21'h000000);
		stop_test;
	end
endmodule
